// File: sbsram_defs.vh
`ifndef SBSRAM_DEFS_VH
`define SBSRAM_DEFS_VH

// ----------------------------------------
// Geometry
// ----------------------------------------
`define SBSRAM_ADDR_W      19
`define SBSRAM_DATA_W      16
`define SBSRAM_PAR_W       2
`define SBSRAM_DEPTH       524288

// ----------------------------------------
// Burst counter
// ----------------------------------------
`define SBSRAM_BURST_W     2
`define SBSRAM_BURST_RST   2'h0

// ----------------------------------------
// Pin filter and reset values
// ----------------------------------------
`define SBSRAM_SYNC_STAGES 3
`define SBSRAM_ADDR_RST    19'h00000
`define SBSRAM_DATA_RST    16'h0000
`define SBSRAM_PAR_RST     2'h0

`endif

// File: sbsram_burst_seq.v
`include "sbsram_defs.vh"

// Wraparound two-bit burst counter with linear or interleaved order
module sbsram_burst_seq (
    input  wire                        clk_sys_i,
    input  wire                        reset_n_i,
    input  wire                        load_i,
    input  wire [`SBSRAM_BURST_W-1:0]  start_i,
    input  wire                        advance_i,
    input  wire                        interleave_i,
    output wire [`SBSRAM_BURST_W-1:0]  addr_o
);
    reg [`SBSRAM_BURST_W-1:0] start_q;
    reg [`SBSRAM_BURST_W-1:0] count_q;
    reg [`SBSRAM_BURST_W-1:0] count_d;

    always @* begin
        count_d = count_q;
        if (load_i) begin
            count_d = `SBSRAM_BURST_RST;
        end else if (advance_i) begin
            count_d = count_q + 2'h1; // R12
        end
    end

    always @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            start_q <= `SBSRAM_BURST_RST;
            count_q <= `SBSRAM_BURST_RST;
        end else begin
            count_q <= count_d; // R1
            if (load_i) begin
                start_q <= start_i; // R4
            end
        end
    end

    // Interleaved walks by XOR, linear by addition
    assign addr_o = interleave_i ? (start_q ^ count_q) : (start_q + count_q); // R13
endmodule

// File: sbsram_port.v
`include "sbsram_defs.vh"

// Operation
// R1: Advance input low increments burst address
// R2: Processor strobe low captures address
// R3: Controller strobe low captures address
// R4: Any capture loads low two bits
// R5: Both strobes: processor strobe wins
// R6: Processor strobe ignored when chip disabled; here it still blocks the controller strobe
// R7: Sleep high idles, keeps memory contents
// R8: Host holds sleep low for operation
// R9: Input data registered on rising edge
// R10: Read data one pipeline stage late
// R11: Drive data only while output enable low
// R12: Two-bit wrapping burst counter
// R13: Strap low linear, high interleaved
// R14: Strap changes only while idle
module sbsram_port (
    input  wire                        clk_sys_i,
    input  wire                        reset_n_i,
    input  wire [`SBSRAM_ADDR_W-1:0]   addr_i,
    input  wire                        processor_addr_strobe_n_i,
    input  wire                        controller_addr_strobe_n_i,
    input  wire                        primary_chip_enable_n_i,
    input  wire                        burst_advance_n_i,
    input  wire                        write_n_i,
    input  wire                        sleep_request_i,
    input  wire                        output_enable_n_i,
    input  wire                        burst_mode_i,
    input  wire [`SBSRAM_DATA_W-1:0]   data_lines_i,
    input  wire [`SBSRAM_PAR_W-1:0]    parity_data_lines_i,
    output reg  [`SBSRAM_DATA_W-1:0]   data_lines_o,
    output reg  [`SBSRAM_PAR_W-1:0]    parity_data_lines_o,
    output reg                         data_oe_o,
    output reg                         sleeping_o
);
    localparam WORD_W = `SBSRAM_DATA_W + `SBSRAM_PAR_W;

    // ----------------------------------------
    // Memory array
    // ----------------------------------------
    reg [WORD_W-1:0] mem_q [0:`SBSRAM_DEPTH-1];

    // ----------------------------------------
    // Asynchronous pin filters
    // ----------------------------------------
    reg [`SBSRAM_SYNC_STAGES-1:0] sleep_sync_q;
    reg [`SBSRAM_SYNC_STAGES-1:0] oe_sync_q;
    reg [`SBSRAM_SYNC_STAGES-1:0] mode_sync_q;
    reg                           sleep_q;
    reg                           oe_n_q;
    reg                           mode_q;

    function filt_next;
        input [`SBSRAM_SYNC_STAGES-1:0] s;
        input                           cur;
        begin
            // Second and third stage must agree before a change counts
            filt_next = (s[1] == s[2]) ? s[1] : cur;
        end
    endfunction

    always @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sleep_sync_q <= 3'h0;
            oe_sync_q    <= 3'h7;
            mode_sync_q  <= 3'h7;
            sleep_q      <= 1'b0;
            oe_n_q       <= 1'b1;
            mode_q       <= 1'b1;
        end else begin
            sleep_sync_q <= {sleep_sync_q[1:0], sleep_request_i};
            oe_sync_q    <= {oe_sync_q[1:0], output_enable_n_i};
            mode_sync_q  <= {mode_sync_q[1:0], burst_mode_i};
            sleep_q      <= filt_next(sleep_sync_q, sleep_q); // R8
            oe_n_q       <= filt_next(oe_sync_q, oe_n_q);
            mode_q       <= filt_next(mode_sync_q, mode_q); // R14
        end
    end

    // ----------------------------------------
    // Strobe decode
    // ----------------------------------------
    wire proc_take = !processor_addr_strobe_n_i && !primary_chip_enable_n_i; // R6
    // Controller strobe only counts while the processor strobe is high
    wire ctrl_take = !controller_addr_strobe_n_i && processor_addr_strobe_n_i; // R5
    // Sleep blocks all new accesses; array contents are left untouched
    wire load      = (proc_take || ctrl_take) && !sleep_q; // R7

    reg [`SBSRAM_ADDR_W-1:0] addr_q;
    reg                      active_q;
    reg                      wr_q;
    reg [WORD_W-1:0]         din_q;

    wire [`SBSRAM_BURST_W-1:0] burst_addr;

    sbsram_burst_seq u_burst (
        .clk_sys_i    (clk_sys_i),
        .reset_n_i    (reset_n_i),
        .load_i       (load),
        .start_i      (addr_i[`SBSRAM_BURST_W-1:0]), // R4
        .advance_i    (!burst_advance_n_i && active_q && !sleep_q), // R1
        .interleave_i (mode_q), // R13
        .addr_o       (burst_addr) // R12
    );

    wire [`SBSRAM_ADDR_W-1:0] cur_addr =
        {addr_q[`SBSRAM_ADDR_W-1:`SBSRAM_BURST_W], burst_addr};

    // ----------------------------------------
    // Address and data capture
    // ----------------------------------------
    always @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            addr_q   <= `SBSRAM_ADDR_RST;
            active_q <= 1'b0;
            wr_q     <= 1'b0;
            din_q    <= {WORD_W{1'b0}};
        end else begin
            if (load) begin
                addr_q   <= addr_i; // R2 R3
                active_q <= 1'b1;
            end
            // A write may ride on the very first strobe of the run
            wr_q  <= !write_n_i && (active_q || load) && !sleep_q;
            din_q <= {parity_data_lines_i, data_lines_i}; // R9
        end
    end

    // ----------------------------------------
    // Array access: write late, read one stage
    // ----------------------------------------
    // No reset on the array path so the memory maps to RAM
    always @(posedge clk_sys_i) begin
        if (wr_q) begin
            mem_q[cur_addr] <= din_q;
        end
    end

    // Read word goes straight into the output flops: one stage
    wire [WORD_W-1:0] rd_word = mem_q[cur_addr];

    // ----------------------------------------
    // Output stage
    // ----------------------------------------
    always @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            data_lines_o        <= `SBSRAM_DATA_RST;
            parity_data_lines_o <= `SBSRAM_PAR_RST;
            data_oe_o           <= 1'b0;
            sleeping_o          <= 1'b0;
        end else begin
            data_lines_o        <= rd_word[`SBSRAM_DATA_W-1:0]; // R10
            parity_data_lines_o <= rd_word[WORD_W-1:`SBSRAM_DATA_W]; // R10
            data_oe_o           <= !oe_n_q && active_q && !sleep_q; // R11
            sleeping_o          <= sleep_q; // R7
        end
    end
endmodule

// File: sbsram_port_properties.sv
module sbsram_port_chk (
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic output_enable_n_i,
    input wire logic sleep_request_i,
    input wire logic data_oe_o,
    input wire logic sleeping_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking dc @(posedge clk_sys_i);
    endclocking
    default disable iff (!reset_n_i);
    // ----------------------------
    // Pin changes reach the outputs after 5 edges
    // ----------------------------
    oe_on_a: assert property (
        (!output_enable_n_i && !sleep_request_i)[*8] |-> data_oe_o)
        else $error("drive not on");
    oe_off_a: assert property (output_enable_n_i[*6] |-> !data_oe_o)
        else $error("drive not off");
    oe_rise_a: assert property ($rose(data_oe_o) |->
        !$past(output_enable_n_i, 2) && !$past(sleep_request_i, 2))
        else $error("drive rose early");
    oe_fall_a: assert property ($fell(data_oe_o) |->
        $past(output_enable_n_i, 2) || $past(sleep_request_i, 2))
        else $error("drive fell early");
    sleep_on_a: assert property (sleep_request_i[*6] |-> sleeping_o)
        else $error("sleep not entered");
    sleep_off_a: assert property (!sleep_request_i[*6] |-> !sleeping_o)
        else $error("sleep not left");
    sleep_rise_a: assert property ($rose(sleeping_o) |-> $past(sleep_request_i, 2))
        else $error("sleep rose early");
    sleep_fall_a: assert property ($fell(sleeping_o) |-> !$past(sleep_request_i, 2))
        else $error("sleep fell early");
endmodule

bind sbsram_port sbsram_port_chk i_sbsram_port_chk (
    .clk_sys_i         (clk_sys_i),
    .reset_n_i         (reset_n_i),
    .output_enable_n_i (output_enable_n_i),
    .sleep_request_i   (sleep_request_i),
    .data_oe_o         (data_oe_o),
    .sleeping_o        (sleeping_o)
);

// File: sbsram_host.sv
module sbsram_host (
    input  wire        clk_sys_i,
    input  wire        data_oe_i,
    input  wire [17:0] dev_data_i,
    output reg  [4:0]  ctl_o,
    output reg  [18:0] addr_o,
    output wire [17:0] bus_o
);
    timeunit 1ns;
    timeprecision 1ps;
    reg [17:0] drv_q;
    // Released lines show the inverse, so a stale value never matches
    assign bus_o = data_oe_i ? dev_data_i : (ctl_o[0] ? ~drv_q : drv_q);
    initial begin
        ctl_o = 5'h1f;
        addr_o = 19'h0;
        drv_q = 18'h0;
    end
    // Control order: processor, controller, enable, advance, write
    task cyc(input [4:0] c, input [18:0] a, input [17:0] d);
        @(negedge clk_sys_i);
        ctl_o = c;
        addr_o = a;
        drv_q = d;
    endtask
endmodule

// File: sbsram_port_test.sv
module sbsram_port_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam [18:0] BASE = 19'h4a5c8;
    reg         clk_sys_i;
    reg         reset_n_i;
    reg         sleep_req;
    reg         oe_n;
    reg         mode;
    wire [4:0]  ctl;
    wire [18:0] addr;
    wire [17:0] bus;
    wire [15:0] dq;
    wire [1:0]  dqp;
    wire        oe;
    wire        slp;
    integer     n_fail;
    integer     n_checks;
    integer     cyc_n;
    sbsram_host i_sbsram_host (.clk_sys_i(clk_sys_i), .data_oe_i(oe), .dev_data_i({dqp, dq}),
        .ctl_o(ctl), .addr_o(addr), .bus_o(bus));
    sbsram_port i_sbsram_port (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .addr_i(addr),
        .processor_addr_strobe_n_i(ctl[4]), .controller_addr_strobe_n_i(ctl[3]),
        .primary_chip_enable_n_i(ctl[2]), .burst_advance_n_i(ctl[1]), .write_n_i(ctl[0]),
        .sleep_request_i(sleep_req), .output_enable_n_i(oe_n), .burst_mode_i(mode),
        .data_lines_i(bus[15:0]), .parity_data_lines_i(bus[17:16]), .data_lines_o(dq),
        .parity_data_lines_o(dqp), .data_oe_o(oe), .sleeping_o(slp));
    function [17:0] f(input [18:0] a);
        f = {a[1:0], a[15:0] ^ 16'h5a3c};
    endfunction
    task chk(input string nm, input [17:0] e, input [17:0] s);
        n_checks = n_checks + 1;
        if (e !== s) begin
            n_fail = n_fail + 1;
            $display("MISMATCH %s exp %h got %h", nm, e, s);
        end
    endtask
    task idle(input integer n);
        repeat (n) i_sbsram_host.cyc(5'h1f, 19'h0, 18'h0);
    endtask
    task t_burst(input m);
        reg [18:0] k;
        begin
            mode = m;
            oe_n = 1'b1;
            idle(6);
            chk("oe", 18'h0, {17'h0, oe});
            for (k = 0; k < 4; k = k + 1) begin
                i_sbsram_host.cyc(5'h12, BASE + k, f(BASE + k));
                idle(1);
            end
            oe_n = 1'b0;
            idle(6);
            chk("oe", 18'h1, {17'h0, oe});
            for (k = 0; k < 6; k = k + 1) begin
                i_sbsram_host.cyc(k == 0 ? 5'h0b : (k < 4 ? 5'h19 : 5'h1f), BASE + 1, 18'h0);
                if (k > 1) chk("burst",
                    f({BASE[18:2], m ? 2'h1 ^ (k[1:0] - 2'h2) : k[1:0] - 2'h1}),
                    {dqp, dq});
            end
        end
    endtask
    task t_refuse(input [4:0] c);
        i_sbsram_host.cyc(c, BASE + 19'h2, 18'h0);
        idle(3);
        chk("hold", f(BASE), {dqp, dq});
    endtask
    task t_sleep;
        sleep_req = 1'b1;
        idle(6);
        chk("sleep", 18'h1, {17'h0, slp});
        chk("oe", 18'h0, {17'h0, oe});
        i_sbsram_host.cyc(5'h0b, BASE + 19'h2, 18'h0);
        idle(2);
        sleep_req = 1'b0;
        idle(6);
        chk("sleep", 18'h0, {17'h0, slp});
        chk("asleep", f(BASE), {dqp, dq});
        i_sbsram_host.cyc(5'h0b, BASE + 19'h3, 18'h0);
        idle(3);
        chk("kept", f(BASE + 19'h3), {dqp, dq});
    endtask
    task summarize;
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    always @(posedge clk_sys_i) begin
        cyc_n <= cyc_n + 1;
        if (cyc_n == 2000) begin
            n_fail = n_fail + 1;
            summarize;
        end
    end
    initial begin
        n_fail = 0;
        n_checks = 0;
        cyc_n = 0;
        reset_n_i = 1'b0;
        sleep_req = 1'b0;
        oe_n = 1'b1;
        mode = 1'b1;
        repeat (2) @(negedge clk_sys_i);
        reset_n_i = 1'b1;
        t_burst(1'b1);
        t_burst(1'b0);
        t_refuse(5'h0f);
        t_refuse(5'h07);
        t_sleep;
        summarize;
    end
endmodule
